// ### src/tpwc_top.sv
// Purpose: two timer pairs with 16-bit capture and 10-bit PWM on AXI4-Lite
// Assumes: pins are asynchronous, one clock, synchronous active-low reset
// Notes: registers other than the 16-bit count are 8 bits wide in the low byte of each word
// Function
// - wide capture acts like 8-bit, sixteen bits wide
// - lower timer clock chosen by three-bit field
// - two PWM channels of ten-bit resolution
// - period is low byte plus bits 3:2
// - duty is low byte plus bits 1:0
// - working duty loads at period match
// - sense bit picks duty portion level
// - duty equal nonzero period holds sense level
// - zero duty holds inverse sense level
// - new duty shows after current period
// - period change keeps absolute duty time
// - selected edge captures count, raises event
// - capture clears counter, counting resumes
// - capture edge falling, rising or both
// - capture and compare share one address
//
// The register addresses and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/10ps
module tpwc_top
  import tpwc_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  input  wire logic [TPWC_AW-1:0] awaddr,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic      [1:0]         bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [TPWC_AW-1:0] araddr,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic      [31:0]        rdata,
  output logic      [1:0]         rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  input  wire logic [3:0]         capture_input,
  input  wire logic [1:0]         event_input,
  output logic                    pwm_a_output,
  output logic                    pwm_a_output_en,
  output logic                    pwm_b_output,
  output logic                    pwm_b_output_en,
  output logic      [3:0]         capture_event,
  output logic      [3:0]         match_event
);
  logic [7:0]            lower_mode [2];
  logic [7:0]            upper_mode [2];
  logic [7:0]            lower_cmp  [2];
  logic [7:0]            upper_cmp  [2];
  logic [7:0]            period_low [2];
  logic [7:0]            upper_bits [2];
  logic [7:0]            duty_low   [2];
  logic [3:0]            flag       [2];
  logic [7:0]            port_sel;
  logic [7:0]            edge_sel;
  logic [TPWC_PSC_W-1:0] psc;
  logic [5:0]            pin_s1;
  logic [5:0]            pin_s2;
  logic [5:0]            pin_s3;
  logic                  aw_full;
  logic                  w_full;
  logic [TPWC_AW-1:0]    aw_addr;
  logic [7:0]            wd;
  logic                  w_lane0;
  logic [7:0]            capt_lo    [2];
  logic [7:0]            capt_hi    [2];
  logic [15:0]           cnt        [2];
  logic [1:0]            capt_ev    [2];
  logic [1:0]            match_ev   [2];
  logic [1:0]            pwm_lvl;
  logic [15:0]           pair_rd    [2];

  // write channel: address and data held until both are in
  wire       wr_go = aw_full && w_full && !bvalid;
  wire       wr_en = wr_go && w_lane0;
  wire [1:0] we_lm = pair_hit(aw_addr, TPWC_OFS_LOWER_MODE);
  wire [1:0] we_um = pair_hit(aw_addr, TPWC_OFS_UPPER_MODE);
  wire [1:0] we_ld = pair_hit(aw_addr, TPWC_OFS_LOWER_DATA);
  wire [1:0] we_ud = pair_hit(aw_addr, TPWC_OFS_UPPER_DATA);
  wire [1:0] we_pl = pair_hit(aw_addr, TPWC_OFS_PERIOD_LOW);
  wire [1:0] we_ub = pair_hit(aw_addr, TPWC_OFS_UPPER_BITS);
  wire [1:0] we_dl = pair_hit(aw_addr, TPWC_OFS_DUTY_LOW);
  wire [1:0] we_cn = pair_hit(aw_addr, TPWC_OFS_COUNT);
  wire [1:0] we_st = pair_hit(aw_addr, TPWC_OFS_STATUS);
  wire       we_ps = aw_addr == TPWC_OFS_PORT_SEL;
  wire       we_es = aw_addr == TPWC_OFS_EDGE_SEL;
  wire       wr_ok = |{we_lm, we_um, we_ld, we_ud, we_pl, we_ub, we_dl, we_cn, we_st,
                       we_ps, we_es};

  assign awready = !aw_full && !bvalid;
  assign wready  = !w_full && !bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full <= 1'b0;
      aw_addr <= '0;
    end else if (awvalid && awready) begin
      aw_full <= 1'b1;
      aw_addr <= awaddr;
    end else if (wr_go) begin
      aw_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full  <= 1'b0;
      wd      <= 8'h00;
      w_lane0 <= 1'b0;
    end else if (wvalid && wready) begin
      w_full  <= 1'b1;
      wd      <= wdata[7:0];
      w_lane0 <= wstrb[0];
    end else if (wr_go) begin
      w_full <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp  <= TPWC_RESP_OKAY;
    end else if (wr_go) begin
      bvalid <= 1'b1;
      bresp  <= wr_ok ? TPWC_RESP_OKAY : TPWC_RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // register file; count writes are accepted and dropped
  always_ff @(posedge aclk) begin
    for (int p = 0; p < 2; p++) begin
      if (!aresetn) begin
        lower_mode[p] <= 8'h00;
        upper_mode[p] <= 8'h00;
        lower_cmp[p]  <= 8'h00;
        upper_cmp[p]  <= 8'h00;
        period_low[p] <= 8'h00;
        upper_bits[p] <= 8'h00;
        duty_low[p]   <= 8'h00;
      end else if (wr_en) begin
        if (we_lm[p]) lower_mode[p] <= wd;
        if (we_um[p]) upper_mode[p] <= wd;
        if (we_ld[p]) lower_cmp[p] <= wd;
        if (we_ud[p]) upper_cmp[p] <= wd;
        if (we_pl[p]) period_low[p] <= wd;
        if (we_ub[p]) upper_bits[p] <= wd;
        if (we_dl[p]) duty_low[p] <= wd;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      port_sel <= 8'h00;
      edge_sel <= 8'h00;
    end else if (wr_en) begin
      if (we_ps) port_sel <= wd;
      if (we_es) edge_sel <= wd;
    end
  end

  // sticky event flags, write one to clear; a new event beats the clear
  always_ff @(posedge aclk) begin
    for (int p = 0; p < 2; p++) begin
      if (!aresetn) begin
        flag[p] <= 4'h0;
      end else begin
        flag[p] <= (flag[p] & ~((wr_en && we_st[p]) ? wd[3:0] : 4'h0))
                   | {match_ev[p], capt_ev[p]};
      end
    end
  end

  // read channel
  wire [1:0] re_lm = pair_hit(araddr, TPWC_OFS_LOWER_MODE);
  wire [1:0] re_um = pair_hit(araddr, TPWC_OFS_UPPER_MODE);
  wire [1:0] re_ld = pair_hit(araddr, TPWC_OFS_LOWER_DATA);
  wire [1:0] re_ud = pair_hit(araddr, TPWC_OFS_UPPER_DATA);
  wire [1:0] re_pl = pair_hit(araddr, TPWC_OFS_PERIOD_LOW);
  wire [1:0] re_ub = pair_hit(araddr, TPWC_OFS_UPPER_BITS);
  wire [1:0] re_dl = pair_hit(araddr, TPWC_OFS_DUTY_LOW);
  wire [1:0] re_cn = pair_hit(araddr, TPWC_OFS_COUNT);
  wire [1:0] re_st = pair_hit(araddr, TPWC_OFS_STATUS);
  wire       re_ps = araddr == TPWC_OFS_PORT_SEL;
  wire       re_es = araddr == TPWC_OFS_EDGE_SEL;
  wire       rd_ok = |{re_lm, re_um, re_ld, re_ud, re_pl, re_ub, re_dl, re_cn, re_st,
                       re_ps, re_es};
  wire [15:0] glob_rd = {8'h00, ({8{re_ps}} & port_sel) | ({8{re_es}} & edge_sel)};
  wire [31:0] next_rdata = {16'h0000, pair_rd[0] | pair_rd[1] | glob_rd};

  assign arready = !rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= TPWC_RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= next_rdata;
      rresp  <= rd_ok ? TPWC_RESP_OKAY : TPWC_RESP_SLVERR;
    end else if (rready) begin
      rvalid <= 1'b0;
    end
  end

  // pins: two flops, then a third stage only for edge detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_s1 <= 6'h00;
      pin_s2 <= 6'h00;
      pin_s3 <= 6'h00;
      psc    <= '0;
    end else begin
      pin_s1 <= {event_input, capture_input};
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      psc    <= psc + 1'b1;
    end
  end

  wire [5:0] pin_rise  = pin_s2 & ~pin_s3;
  wire [5:0] pin_fall  = ~pin_s2 & pin_s3;
  wire [1:0] ext_event = pin_rise[5:4] & port_sel[TPWC_PS_EVENT +: 2];
  wire [3:0] capt_edge;

  for (genvar i = 0; i < 4; i++) begin : g_edge
    assign capt_edge[i] = port_sel[TPWC_PS_CAPT + i]
                          && ((edge_sel[2*i + TPWC_EDGE_RISE] && pin_rise[i])
                          || (edge_sel[2*i + TPWC_EDGE_FALL] && pin_fall[i]));
  end

  for (genvar p = 0; p < 2; p++) begin : g_pair
    // in capture mode the shared address reads the captured byte
    wire lo_capt_rd = lower_mode[p][TPWC_LM_CAPT]
                      || (pair_joined(upper_mode[p]) && upper_mode[p][TPWC_UM_CAPT]);
    wire hi_capt_rd = upper_mode[p][TPWC_UM_CAPT];
    wire [7:0] ld_rd = lo_capt_rd ? capt_lo[p] : lower_cmp[p];
    wire [7:0] ud_rd = hi_capt_rd ? capt_hi[p] : upper_cmp[p];

    assign pair_rd[p] = {8'h00, ({8{re_lm[p]}} & lower_mode[p])
                        | ({8{re_um[p]}} & upper_mode[p])
                        | ({8{re_ld[p]}} & ld_rd)
                        | ({8{re_ud[p]}} & ud_rd)
                        | ({8{re_pl[p]}} & period_low[p])
                        | ({8{re_ub[p]}} & upper_bits[p])
                        | ({8{re_dl[p]}} & duty_low[p])
                        | ({8{re_st[p]}} & {4'h0, flag[p]})}
                        | ({16{re_cn[p]}} & cnt[p]);

    tpwc_pair #(
      .PAIR_B (p == 1),
      .PWM_W  (TPWC_PWM_W)
    ) u_pair (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .psc         (psc),
      .ext_event   (ext_event[p]),
      .capt_edge   (capt_edge[2*p +: 2]),
      .lower_mode  (lower_mode[p]),
      .upper_mode  (upper_mode[p]),
      .lower_cmp   (lower_cmp[p]),
      .upper_cmp   (upper_cmp[p]),
      .period_low  (period_low[p]),
      .upper_bits  (upper_bits[p]),
      .duty_low    (duty_low[p]),
      .lower_capt  (capt_lo[p]),
      .upper_capt  (capt_hi[p]),
      .count       (cnt[p]),
      .pwm_level   (pwm_lvl[p]),
      .capt_event  (capt_ev[p]),
      .match_event (match_ev[p])
    );
  end

  assign capture_event   = {capt_ev[1], capt_ev[0]};
  assign match_event     = {match_ev[1], match_ev[0]};
  assign pwm_a_output_en = port_sel[TPWC_PS_PWM];
  assign pwm_b_output_en = port_sel[TPWC_PS_PWM + 1];

  // pin stays low until software hands it to the PWM
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_a_output <= 1'b0;
      pwm_b_output <= 1'b0;
    end else begin
      pwm_a_output <= port_sel[TPWC_PS_PWM] && pwm_lvl[0];
      pwm_b_output <= port_sel[TPWC_PS_PWM + 1] && pwm_lvl[1];
    end
  end

  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_pin_gate: assert property (
    !port_sel[TPWC_PS_PWM] |=> !pwm_a_output)
    else $error("PWM pin driven while disabled");
  a_capt_read: assert property (
    arvalid && arready && araddr == TPWC_OFS_LOWER_DATA && lower_mode[0][TPWC_LM_CAPT]
    |=> rvalid && rdata[7:0] == $past(capt_lo[0]))
    else $error("shared address did not return captured value");
  a_no_edge: assert property (
    pin_s2[0] == pin_s3[0] |-> !capt_edge[0])
    else $error("capture fired without an input edge");
  a_write_resp: assert property (
    wr_go |=> bvalid && !aw_full && !w_full)
    else $error("write did not answer in one cycle");
  c_write: cover property (bvalid && bready);
  c_read_err: cover property (rvalid && rresp == TPWC_RESP_SLVERR);
  c_pwm_pin: cover property (pwm_a_output ##1 !pwm_a_output);
endmodule : tpwc_top

// ### src/tpwc_pkg.sv
// Purpose: shared constants for the timer pair capture and PWM block
// Assumes: AXI4-Lite byte addresses, 8-bit registers in the low byte except the 16-bit count
// Notes: pair b repeats the pair a map at TPWC_PAIR_B_BASE
package tpwc_pkg;
  localparam int TPWC_DW    = 8;
  localparam int TPWC_PWM_W = 10;
  localparam int TPWC_PSC_W = 11;
  localparam int TPWC_AW    = 8;

  localparam logic [7:0] TPWC_PAIR_B_BASE     = 8'h40;
  localparam logic [7:0] TPWC_OFS_LOWER_MODE  = 8'h00;
  localparam logic [7:0] TPWC_OFS_UPPER_MODE  = 8'h04;
  localparam logic [7:0] TPWC_OFS_LOWER_DATA  = 8'h08;
  localparam logic [7:0] TPWC_OFS_UPPER_DATA  = 8'h0C;
  localparam logic [7:0] TPWC_OFS_PERIOD_LOW  = 8'h10;
  localparam logic [7:0] TPWC_OFS_UPPER_BITS  = 8'h14;
  localparam logic [7:0] TPWC_OFS_DUTY_LOW    = 8'h18;
  localparam logic [7:0] TPWC_OFS_COUNT       = 8'h1C;
  localparam logic [7:0] TPWC_OFS_STATUS      = 8'h20;
  localparam logic [7:0] TPWC_OFS_PORT_SEL    = 8'h80;
  localparam logic [7:0] TPWC_OFS_EDGE_SEL    = 8'h84;

  localparam int TPWC_LM_CLK   = 0;
  localparam int TPWC_LM_RUN   = 4;
  localparam int TPWC_LM_CAPT  = 5;
  localparam int TPWC_UM_CLK   = 0;
  localparam int TPWC_UM_RUN   = 2;
  localparam int TPWC_UM_PWM   = 3;
  localparam int TPWC_UM_CAPT  = 5;
  localparam int TPWC_UM_JOIN  = 6;
  localparam int TPWC_UM_SENSE = 7;
  localparam int TPWC_UB_DUTY  = 0;
  localparam int TPWC_UB_PER   = 2;
  localparam int TPWC_PS_CAPT  = 0;
  localparam int TPWC_PS_EVENT = 4;
  localparam int TPWC_PS_PWM   = 6;
  localparam int TPWC_EDGE_FALL = 0;
  localparam int TPWC_EDGE_RISE = 1;

  localparam logic [2:0] TPWC_LO_CLK_EXT     = 3'h7;
  localparam logic [1:0] TPWC_UP_CLK_CASCADE = 2'h3;
  localparam logic [1:0] TPWC_RESP_OKAY      = 2'h0;
  localparam logic [1:0] TPWC_RESP_SLVERR    = 2'h2;

  // tick when the low e bits of the free prescaler are all ones
  function automatic logic psc_tick(input logic [TPWC_PSC_W-1:0] psc, input logic [3:0] e);
    logic t;
    t = 1'b1;
    for (int i = 0; i < TPWC_PSC_W; i++) begin
      if (i < int'(e) && !psc[i]) t = 1'b0;
    end
    return t;
  endfunction : psc_tick

  // log2 of the lower timer divide ratio
  function automatic logic [3:0] lo_exp(input logic pb, input logic [2:0] sel);
    case ({pb, sel})
      4'h0, 4'h8: lo_exp = 4'h1;
      4'h1, 4'h9: lo_exp = 4'h2;
      4'h2, 4'hA: lo_exp = 4'h3;
      4'h3:       lo_exp = 4'h5;
      4'h4:       lo_exp = 4'h7;
      4'h5:       lo_exp = 4'h9;
      4'h6:       lo_exp = 4'hB;
      4'hB:       lo_exp = 4'h4;
      4'hC:       lo_exp = 4'h6;
      4'hD:       lo_exp = 4'h8;
      default:    lo_exp = 4'hA;
    endcase
  endfunction : lo_exp

  // log2 of the upper timer divide ratio
  function automatic logic [3:0] up_exp(input logic pb, input logic [1:0] sel);
    case ({pb, sel})
      3'h1:    up_exp = 4'h1;
      3'h2:    up_exp = 4'h3;
      3'h5:    up_exp = 4'h2;
      3'h6:    up_exp = 4'h4;
      default: up_exp = 4'h0;
    endcase
  endfunction : up_exp

  function automatic logic pair_joined(input logic [7:0] um);
    return um[TPWC_UM_JOIN] && um[TPWC_UM_CLK +: 2] == TPWC_UP_CLK_CASCADE;
  endfunction : pair_joined

  function automatic logic [1:0] pair_hit(input logic [7:0] a, input logic [7:0] ofs);
    return {a == (ofs | TPWC_PAIR_B_BASE), a == ofs};
  endfunction : pair_hit
endpackage : tpwc_pkg

// ### src/tpwc_pair.sv
// Purpose: one timer pair: two 8-bit timers, 16-bit join, capture, PWM
// Assumes: capture edges and event edges arrive as one-cycle pulses
// Notes: the PWM borrows the upper timer and its clock select
`timescale 1ns/10ps
module tpwc_pair
  import tpwc_pkg::*;
#(
  parameter bit PAIR_B = 1'b0,
  parameter int PWM_W  = TPWC_PWM_W
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic [TPWC_PSC_W-1:0] psc,
  input  wire logic                  ext_event,
  input  wire logic [1:0]            capt_edge,
  input  wire logic [7:0]            lower_mode,
  input  wire logic [7:0]            upper_mode,
  input  wire logic [7:0]            lower_cmp,
  input  wire logic [7:0]            upper_cmp,
  input  wire logic [7:0]            period_low,
  input  wire logic [7:0]            upper_bits,
  input  wire logic [7:0]            duty_low,
  output logic      [7:0]            lower_capt,
  output logic      [7:0]            upper_capt,
  output logic      [15:0]           count,
  output logic                       pwm_level,
  output logic      [1:0]            capt_event,
  output logic      [1:0]            match_event
);
  if (PWM_W != TPWC_DW + 2) begin : g_bad_width
    $error("tpwc_pair: PWM width must equal 8 plus 2 upper bits");
  end

  logic [7:0]       cnt_lo;
  logic [7:0]       cnt_hi;
  logic [PWM_W-1:0] pwm_cnt;
  logic [PWM_W-1:0] duty_work;

  wire [2:0]  lo_sel   = lower_mode[TPWC_LM_CLK +: 3];
  wire [1:0]  up_sel   = upper_mode[TPWC_UM_CLK +: 2];
  wire        lo_run   = lower_mode[TPWC_LM_RUN];
  wire        up_run   = upper_mode[TPWC_UM_RUN];
  wire        joined   = pair_joined(upper_mode);
  wire        pwm_on   = upper_mode[TPWC_UM_PWM] && !joined;
  wire        sense    = upper_mode[TPWC_UM_SENSE];
  wire [15:0] wide_cnt = {cnt_hi, cnt_lo};
  wire        lo_tick  = lo_run && (lo_sel == TPWC_LO_CLK_EXT ? ext_event
                         : psc_tick(psc, lo_exp(PAIR_B, lo_sel)));
  wire        lo_match = lo_tick && (joined ? wide_cnt == {upper_cmp, lower_cmp}
                         : cnt_lo == lower_cmp);
  wire        up_tick  = up_run && (up_sel == TPWC_UP_CLK_CASCADE ? lo_match
                         : psc_tick(psc, up_exp(PAIR_B, up_sel)));
  wire        up_match = up_tick && !joined && !pwm_on && cnt_hi == upper_cmp;
  // a joined pair listens on the lower input, armed by the upper bit
  wire        lo_hit   = capt_edge[0] && (joined ? upper_mode[TPWC_UM_CAPT]
                         : lower_mode[TPWC_LM_CAPT]);
  wire        up_hit   = capt_edge[1] && !joined && !pwm_on && upper_mode[TPWC_UM_CAPT];
  wire        lo_clear = !lo_run || lo_hit || lo_match;
  wire        hi_clear = joined ? lo_clear : (!up_run || up_hit || up_match || pwm_on);
  wire        hi_inc   = joined ? (lo_tick && &cnt_lo) : up_tick;
  wire [7:0]  next_lo  = lo_clear ? 8'h00 : lo_tick ? cnt_lo + 8'h01 : cnt_lo;
  wire [7:0]  next_hi  = hi_clear ? 8'h00 : hi_inc ? cnt_hi + 8'h01 : cnt_hi;

  wire [PWM_W-1:0] per    = {upper_bits[TPWC_UB_PER +: 2], period_low};
  wire [PWM_W-1:0] duty_m = {upper_bits[TPWC_UB_DUTY +: 2], duty_low};
  wire             pwm_tick = pwm_on && up_tick;
  // >= lets a period cut below the running count wrap at once
  wire             pwm_wrap = pwm_tick && pwm_cnt >= per;
  wire             next_level = duty_work == '0 ? !sense
                              : duty_work == per ? sense
                              : (pwm_cnt < duty_work) ? sense : !sense;

  assign count = wide_cnt;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_lo <= 8'h00;
      cnt_hi <= 8'h00;
    end else begin
      cnt_lo <= next_lo;
      cnt_hi <= next_hi;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lower_capt  <= 8'h00;
      upper_capt  <= 8'h00;
      capt_event  <= 2'h0;
      match_event <= 2'h0;
    end else begin
      capt_event  <= {up_hit, lo_hit};
      match_event <= {up_match, lo_match};
      if (lo_hit) lower_capt <= cnt_lo;
      if (lo_hit && joined) upper_capt <= cnt_hi;
      else if (up_hit) upper_capt <= cnt_hi;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pwm_cnt   <= '0;
      duty_work <= '0;
      pwm_level <= 1'b0;
    end else begin
      pwm_level <= pwm_on ? next_level : 1'b0;
      if (!pwm_on || pwm_wrap) begin
        pwm_cnt   <= '0;
        duty_work <= duty_m;
      end else if (pwm_tick) begin
        pwm_cnt <= pwm_cnt + 1'b1;
      end
    end
  end

  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_zero_duty: assert property (
    pwm_on && duty_work == '0 |=> pwm_level == !$past(sense))
    else $error("zero duty does not hold the idle level");
  a_full_duty: assert property (
    pwm_on && duty_work == per && duty_work != '0 |=> pwm_level == $past(sense))
    else $error("full duty does not hold the active level");
  a_duty_hold: assert property (
    pwm_on && !pwm_wrap |=> duty_work == $past(duty_work))
    else $error("working duty changed inside a period");
  a_duty_load: assert property (
    pwm_wrap |=> duty_work == $past(duty_m) && pwm_cnt == '0)
    else $error("duty not moved to working copy at wrap");
  a_capt_clear: assert property (
    lo_hit |=> cnt_lo == 8'h00 && lower_capt == $past(cnt_lo))
    else $error("capture did not latch and clear the counter");
  a_wide_capt: assert property (
    lo_hit && joined |=> upper_capt == $past(cnt_hi) && cnt_hi == 8'h00)
    else $error("wide capture high byte wrong");
  a_ext_clock: assert property (
    lo_run && lo_sel == TPWC_LO_CLK_EXT && !ext_event && !lo_hit
    |=> cnt_lo == $past(cnt_lo))
    else $error("lower timer moved without its external clock");
  c_pwm_wrap: cover property (pwm_wrap && duty_work != '0);
  c_wide_capt: cover property (lo_hit && joined);
endmodule : tpwc_pair

// ### sim/tpwc_far_end.sv
// Purpose: far side source of capture pin edges
// Assumes: one pulse on fire gives one rising edge on pin 0
// Notes: level held 4 cycles so the pin synchroniser sees it
`timescale 1ns/10ps
module tpwc_far_end (
  input  wire logic       aclk,
  input  wire logic       fire,
  output logic      [3:0] capture_input,
  output logic      [1:0] event_input
);
  logic [2:0] hold = 3'h0;
  always @(posedge aclk) hold <= fire ? 3'h4 : (hold != 3'h0 ? hold - 3'h1 : 3'h0);
  assign capture_input = {3'b000, hold != 3'h0};
  // event pins idle low: no external counting in these tests
  assign event_input   = 2'b00;
endmodule : tpwc_far_end

// ### sim/test_timer_pwm_and_wide_capture.sv
// Purpose: bench for register, PWM and capture paths of pair a
// Assumes: upper clock select 0 ticks every aclk
// Notes: every wait is bounded; a spent bound counts as a failure
`timescale 1ns/10ps
`define TPWC_CHK(g, e) begin checks++; if ((g) !== (e)) begin n_fail++; \
  $display("Error t=%0t got %h exp %h", $time, g, e); end end
module test_timer_pwm_and_wide_capture;
  import tpwc_pkg::*;
  logic        aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0;
  logic        arvalid = 0, rready = 0, fire = 0;
  logic        awready, wready, bvalid, arready, rvalid, pwm_a_output, pwm_a_output_en;
  logic        pwm_b_output, pwm_b_output_en, seen_m = 0;
  logic [7:0]  awaddr = 0, araddr = 0, hi;
  logic [3:0]  wstrb = 4'hF, capture_input, capture_event, match_event;
  logic [1:0]  event_input, bresp, rresp, rs;
  logic [31:0] wdata = 0, rdata, rd;
  logic [7:0]  dt [6] = '{8'h03, 8'h09, 8'h00, 8'h03, 8'h09, 8'h00};
  logic [7:0]  eh [6] = '{8'h03, 8'h0A, 8'h00, 8'h07, 8'h00, 8'h0A};
  int          n_fail = 0, checks = 0, n;
  always #2.5 aclk = ~aclk;
  tpwc_far_end far (.aclk(aclk), .fire(fire), .capture_input(capture_input),
    .event_input(event_input));
  tpwc_top dut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .capture_input(capture_input), .event_input(event_input), .pwm_a_output(pwm_a_output),
    .pwm_a_output_en(pwm_a_output_en), .pwm_b_output(pwm_b_output),
    .pwm_b_output_en(pwm_b_output_en), .capture_event(capture_event),
    .match_event(match_event));
  // remembers that lower timer a reached its compare at least once
  always @(negedge aclk) if (match_event[0]) seen_m <= 1'b1;
  task end_of_test;
    $display("checks %0d mismatches %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    int k;
    logic pa, pw, pb, ha, hw, hb;
    // let the edge that lowered bready pass before raising it again
    @(posedge aclk);
    pa = 1; pw = 1; pb = 1;
    awaddr <= a; wdata <= {24'h00_0000, d}; awvalid <= 1; wvalid <= 1; bready <= 1;
    for (k = 0; pa | pw | pb; k++) begin
      if (k == 50) begin n_fail++; end_of_test(); end
      @(negedge aclk); ha = awvalid & awready; hw = wvalid & wready; hb = bready & bvalid;
      if (hb) rs = bresp;
      @(posedge aclk);
      if (ha) begin awvalid <= 0; pa = 0; end
      if (hw) begin wvalid <= 0; pw = 0; end
      if (hb) begin bready <= 0; pb = 0; end
    end
  endtask : wr
  task automatic rdr(input logic [7:0] a);
    int k;
    logic pa, pr, ha, hr;
    // let the edge that lowered rready pass before raising it again
    @(posedge aclk);
    pa = 1; pr = 1;
    araddr <= a; arvalid <= 1; rready <= 1;
    for (k = 0; pa | pr; k++) begin
      if (k == 50) begin n_fail++; end_of_test(); end
      @(negedge aclk); ha = arvalid & arready; hr = rready & rvalid;
      if (hr) begin rd = rdata; rs = rresp; end
      @(posedge aclk);
      if (ha) begin arvalid <= 0; pa = 0; end
      if (hr) begin rready <= 0; pr = 0; end
    end
  endtask : rdr
  // two pulses 21 cycles apart: 20 edges between captures give 10 ticks at ratio 2
  task automatic fire2;
    repeat (2) begin
      repeat (20) @(posedge aclk);
      fire <= 1;
      @(posedge aclk);
      fire <= 0;
    end
    for (n = 0; n < 20 && capture_event[0] !== 1'b1; n++) @(negedge aclk);
    `TPWC_CHK(capture_event[0], 1'b1)
    @(posedge aclk);
  endtask : fire2
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    wr(TPWC_OFS_PERIOD_LOW, 8'h09);
    `TPWC_CHK(rs, TPWC_RESP_OKAY)
    rdr(TPWC_OFS_PERIOD_LOW); `TPWC_CHK(rd, 32'h0000_0009)
    rdr(8'h30); `TPWC_CHK(rs, TPWC_RESP_SLVERR)
    wr(TPWC_OFS_PORT_SEL, 8'h41);
    `TPWC_CHK(pwm_a_output_en, 1'b1)
    `TPWC_CHK(({pwm_b_output_en, pwm_b_output}), 2'b00)
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      wr(TPWC_OFS_DUTY_LOW, dt[i]);
      wr(TPWC_OFS_UPPER_MODE, {i < 3, 7'h0C});
      repeat (30) @(posedge aclk);
      hi = 0;
      repeat (10) begin @(negedge aclk); hi += {7'h00, pwm_a_output}; end
      @(posedge aclk);
      `TPWC_CHK(hi, eh[i])
    end
    $display("test pwm done");
    wr(TPWC_OFS_EDGE_SEL, 8'h02);
    wr(TPWC_OFS_LOWER_MODE, 8'h30);
    // compare still zero for two ticks: a match on each, then the counter runs free
    wr(TPWC_OFS_LOWER_DATA, 8'hFF);
    fire2();
    rdr(TPWC_OFS_STATUS); `TPWC_CHK(rd[3:0], 4'h5)
    rdr(TPWC_OFS_COUNT); `TPWC_CHK(rd[15:4], 12'h000)
    rdr(TPWC_OFS_LOWER_DATA); `TPWC_CHK(rd, 32'h0000_000A)
    `TPWC_CHK(seen_m, 1'b1)
    wr(TPWC_OFS_EDGE_SEL, 8'h01);
    wr(TPWC_OFS_UPPER_DATA, 8'h01);
    wr(TPWC_OFS_UPPER_MODE, 8'h67);
    wr(TPWC_PAIR_B_BASE | TPWC_OFS_UPPER_MODE, 8'h67);
    wr(TPWC_PAIR_B_BASE | TPWC_OFS_LOWER_MODE, 8'h17);
    fire2();
    rdr(TPWC_OFS_LOWER_DATA); `TPWC_CHK(rd, 32'h0000_000A)
    rdr(TPWC_OFS_UPPER_DATA); `TPWC_CHK(rd, 32'h0000_0000)
    rdr(TPWC_PAIR_B_BASE | TPWC_OFS_COUNT); `TPWC_CHK(rd, 32'h0000_0000)
    $display("test capture done");
    end_of_test();
  end
endmodule : test_timer_pwm_and_wide_capture
